//--- hw/scl_pkg.sv
// Purpose: shared constants and types of the serial image loader
// Assumes: core clock of 50 MHz
// Notes: times are kept in ns, cycle counts derived from them
package scl_pkg;
  localparam int CLK_MHZ = 50;
  // pin slots of the four-pin serial port
  localparam int PIN_SS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SO = 2;
  localparam int PIN_SI = 3;
  localparam int NPINS = 4;
  // synchroniser slots
  localparam int SY_SUP = 0; // four supply-good levels
  localparam int SY_CRST = 4;
  localparam int SY_TEST = 5;
  localparam int SY_PIN = 6; // four pin inputs
  localparam int NSYNC = 10;
  localparam int NSUP = 4;
  localparam int SUP_SPI = 1; // supply slot of the memory supply
  // memory commands
  localparam logic [7:0] CMD_WAKE = 8'hab;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
  localparam logic [23:0] START_ADDR = 24'h000000;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam int CMD_BITS = 8;
  localparam int READ_BITS = 40; // command, address, dummy
  localparam int SH_W = 40;
  // timing
  localparam int PROM_READY_NS = 10000;
  localparam int WAKE_GAP_NS = 10000;
  localparam int RESET_PULSE_NS = 200;
  localparam int PROM_READY_CYC = (PROM_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_GAP_CYC = (WAKE_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 10;
  // half periods of the serial clock, in core cycles
  localparam logic [4:0] HALF_SLOW = 5'h10;
  localparam logic [4:0] HALF_FAST = 5'h04;
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_WAKE = 4'h1,
    ST_GAP = 4'h2,
    ST_READ = 4'h3,
    ST_DATA = 4'h4,
    ST_PGAP = 4'h5,
    ST_PD = 4'h6,
    ST_DONE = 4'h7,
    ST_SLAVE = 4'h8
  } scl_state_e;
endpackage : scl_pkg

//--- hw/scl_fifo.sv
// Purpose: small buffer for received image bytes
// Assumes: one clock, synchronous active-high reset
// Notes: output stage is a register; capacity is DEPTH plus one
`timescale 1ns/1ps
`default_nettype none
module scl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("scl_fifo: DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic empty;
  logic push;
  logic pop;
  logic [WIDTH-1:0] data_ff;
  logic valid_ff;
  // honest full and empty from pointer compare
  assign empty = (wr_ff == rd_ff);
  assign in_ready = !((wr_ff[AW] != rd_ff[AW]) &&
                      (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
  assign push = in_valid && in_ready;
  assign pop = !empty && (!valid_ff || out_ready);
  assign out_valid = valid_ff;
  assign out_data = data_ff;
  // storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ff[AW-1:0]] <= in_data;
  end
  // pointers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
    end
  end
  // registered output stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      valid_ff <= 1'b0;
      data_ff <= '0;
    end
    else if (pop)
    begin
      valid_ff <= 1'b1;
      data_ff <= mem[rd_ff[AW-1:0]];
    end
    else if (out_ready)
      valid_ff <= 1'b0;
  end
endmodule : scl_fifo
`default_nettype wire

//--- hw/scl_loader.sv
// Purpose: reset gathering and serial-memory master loader
// Assumes: 50 MHz ref_clk, all pin inputs asynchronous
// Notes: received image bytes leave through a 16-word buffer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - hold internal reset while any monitored supply is below threshold
// - after memory supply good, wait extra time before releasing reset
// - hold internal reset while config_reset_n is low, once it has stayed low for 200 ns
// - test-port reset command also resets internal logic
// - select pin high at reset release chooses master loading
// - master drives select low-active, clock and data out; reads data in
// - after configuration the four port pins become user I/O (master loading only; in slave mode they stay undriven inputs)
// - read image with fast read 0x0b, 24-bit address, eight dummy bits
// - optional power-down 0xb9 after load; wake 0xab at start
// - serial clock rate selectable; memory must keep up at top rate
// - send wake, deselect, wait 10 us before next command
// - first read always starts at address zero
// - output changes on falling clock edge, input sampled on rising
// - config_reset_n low for 200 ns resets; release restarts from power-on
module scl_loader
  import scl_pkg::*;
#(
  parameter int IMAGE_BITS = 4096,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [NSUP-1:0] supply_good,
  input wire logic config_reset_n,
  input wire logic test_reset_cmd,
  input wire logic rate_fast,
  input wire logic power_down_en,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe_n,
  input wire logic [NPINS-1:0] user_o,
  input wire logic [NPINS-1:0] user_oe_n,
  output logic [NPINS-1:0] gpio_in,
  output logic internal_reset,
  output logic master_mode,
  output logic config_done,
  output logic cfg_valid,
  input wire logic cfg_ready,
  output logic [7:0] cfg_data
);
  initial
  begin
    if (IMAGE_BITS < 8 || (IMAGE_BITS % 8) != 0)
      $error("scl_loader: IMAGE_BITS must be a positive multiple of 8");
  end

  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSUP-1:0] sup_s;
  logic crst_n_s;
  logic test_s;
  logic [NPINS-1:0] pin_s;
  logic [CNT_W-1:0] por_cnt_ff;
  logic por_hold;
  logic [CNT_W-1:0] low_cnt_ff;
  logic creset_hold;
  logic internal_rst_ff;
  logic [4:0] div_ff;
  logic [4:0] half;
  logic tick;
  logic go;
  scl_state_e state_ff;
  logic [SH_W-1:0] sh_ff;
  logic [31:0] cnt_ff;
  logic [CNT_W-1:0] gap_ff;
  logic ss_ff;
  logic sck_ff;
  logic so_ff;
  logic [6:0] rx_ff;
  logic [2:0] rx_cnt_ff;
  logic master_ff;
  logic done_ff;
  logic [NPINS-1:0] pin_o_ff;
  logic [NPINS-1:0] pin_oe_n_ff;
  logic [NPINS-1:0] gpio_in_ff;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;

  // two-stage synchronisers for all pin inputs
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= {pin_i, test_reset_cmd, config_reset_n, supply_good};
      sync2_ff <= sync1_ff;
    end
  end
  assign sup_s = sync2_ff[SY_SUP +: NSUP];
  assign crst_n_s = sync2_ff[SY_CRST];
  assign test_s = sync2_ff[SY_TEST];
  assign pin_s = sync2_ff[SY_PIN +: NPINS];

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !(&sup_s))
      por_cnt_ff <= '0;
    else if (por_cnt_ff != CNT_W'(PROM_READY_CYC))
      por_cnt_ff <= por_cnt_ff + 1'b1;
  end
  assign por_hold = (por_cnt_ff != CNT_W'(PROM_READY_CYC)) || !sup_s[SUP_SPI];

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || crst_n_s)
      low_cnt_ff <= '0;
    else if (low_cnt_ff != CNT_W'(RESET_PULSE_CYC))
      low_cnt_ff <= low_cnt_ff + 1'b1;
  end
  assign creset_hold = (low_cnt_ff == CNT_W'(RESET_PULSE_CYC));

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      internal_rst_ff <= 1'b1;
    else
      internal_rst_ff <= por_hold || creset_hold || test_s;
  end

  // serial clock divider, rate from the rate_fast input
  assign half = rate_fast ? HALF_FAST : HALF_SLOW;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || internal_rst_ff || tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end
  assign tick = (div_ff >= half - 5'h01);
  // full buffer stalls the serial clock
  assign go = tick && (state_ff != ST_DATA || fifo_in_ready);

  // received byte handed to the buffer at its last rising edge
  assign fifo_in_valid = go && (state_ff == ST_DATA) && !sck_ff &&
                         (rx_cnt_ff == 3'h7);
  assign fifo_in_data = {rx_ff, pin_s[PIN_SI]};

  // serial engine and load sequence
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || internal_rst_ff)
    begin
      state_ff <= ST_RESET;
      sh_ff <= '0;
      cnt_ff <= '0;
      gap_ff <= '0;
      ss_ff <= 1'b1;
      sck_ff <= 1'b0;
      so_ff <= 1'b0;
      rx_ff <= '0;
      rx_cnt_ff <= '0;
      master_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_RESET:
        begin
          // strap on select pin picks master loading
          master_ff <= pin_s[PIN_SS];
          if (pin_s[PIN_SS])
          begin
            state_ff <= ST_WAKE;
            ss_ff <= 1'b0;
            sh_ff <= {CMD_WAKE, 32'h00000000};
            so_ff <= CMD_WAKE[7];
            cnt_ff <= 32'(CMD_BITS);
          end
          else
            state_ff <= ST_SLAVE;
        end
        ST_GAP:
        begin
          // select high for the wake gap
          if (gap_ff == CNT_W'(WAKE_GAP_CYC - 1))
          begin
            state_ff <= ST_READ;
            ss_ff <= 1'b0;
            sh_ff <= {CMD_FAST_READ, START_ADDR, DUMMY_BYTE};
            so_ff <= CMD_FAST_READ[7];
            cnt_ff <= 32'(READ_BITS);
          end
          else
            gap_ff <= gap_ff + 1'b1;
        end
        ST_PGAP:
        begin
          if (go)
          begin
            state_ff <= ST_PD;
            ss_ff <= 1'b0;
            sh_ff <= {CMD_POWER_DOWN, 32'h00000000};
            so_ff <= CMD_POWER_DOWN[7];
            cnt_ff <= 32'(CMD_BITS);
          end
        end
        ST_WAKE, ST_READ, ST_DATA, ST_PD:
        begin
          if (go && !sck_ff)
          begin
            // rising edge: sample input, count bit
            sck_ff <= 1'b1;
            cnt_ff <= cnt_ff - 32'h1;
            if (state_ff == ST_DATA)
            begin
              rx_ff <= {rx_ff[5:0], pin_s[PIN_SI]};
              rx_cnt_ff <= rx_cnt_ff + 3'h1;
            end
          end
          else if (go)
          begin
            // falling edge: shift next output bit
            sck_ff <= 1'b0;
            sh_ff <= sh_ff << 1;
            so_ff <= sh_ff[SH_W-2];
            if (cnt_ff == 32'h0)
            begin
              unique case (state_ff)
                ST_WAKE:
                begin
                  // deselect after the last wake bit
                  ss_ff <= 1'b1;
                  gap_ff <= '0;
                  state_ff <= ST_GAP;
                end
                ST_READ:
                begin
                  state_ff <= ST_DATA;
                  cnt_ff <= 32'(IMAGE_BITS);
                end
                ST_DATA:
                begin
                  ss_ff <= 1'b1;
                  state_ff <= power_down_en ? ST_PGAP : ST_DONE;
                end
                default:
                begin
                  ss_ff <= 1'b1;
                  state_ff <= ST_DONE;
                end
              endcase
            end
          end
        end
        ST_DONE, ST_SLAVE:
          state_ff <= state_ff;
        default:
          state_ff <= ST_RESET;
      endcase
    end
  end

  // pin drive, handed to user logic when done
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_o_ff <= '1;
      pin_oe_n_ff <= '1;
      done_ff <= 1'b0;
    end
    else if (state_ff == ST_DONE && !internal_rst_ff)
    begin
      pin_o_ff <= user_o;
      pin_oe_n_ff <= user_oe_n;
      done_ff <= 1'b1;
    end
    else
    begin
      done_ff <= 1'b0;
      pin_o_ff <= {1'b1, so_ff, sck_ff, ss_ff};
      if (master_ff && !internal_rst_ff && state_ff != ST_RESET)
        pin_oe_n_ff <= 4'h8; // SI stays an input
      else
        pin_oe_n_ff <= '1;
    end
  end

  // synchronised pin levels for the application
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      gpio_in_ff <= '0;
    else
      gpio_in_ff <= pin_s;
  end

  scl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(sys_rst || internal_rst_ff),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(cfg_valid),
    .out_ready(cfg_ready),
    .out_data(cfg_data)
  );

  assign pin_o = pin_o_ff;
  assign pin_oe_n = pin_oe_n_ff;
  assign gpio_in = gpio_in_ff;
  assign internal_reset = internal_rst_ff;
  assign master_mode = master_ff;
  assign config_done = done_ff;
endmodule : scl_loader
`default_nettype wire

//--- testbench/scl_asserts.sv
// Purpose: port checks of the serial image loader
// Assumes: one clock domain, bound to scl_loader
// Notes: wire levels of select and clock rebuilt from pins
`timescale 1ns/1ps
`default_nettype none
module scl_asserts
  import scl_pkg::*;
#(
  parameter int IMAGE_BITS = 4096
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [NSUP-1:0] supply_good,
  input wire logic config_reset_n,
  input wire logic [NPINS-1:0] pin_o,
  input wire logic [NPINS-1:0] pin_oe_n,
  input wire logic [NPINS-1:0] user_o,
  input wire logic [NPINS-1:0] user_oe_n,
  input wire logic internal_reset,
  input wire logic master_mode,
  input wire logic config_done,
  input wire logic cfg_valid,
  input wire logic cfg_ready
);
  logic sel, sck, sel_q_ff, sck_q_ff;
  logic [1:0] fall_ff;
  logic [15:0] low_ff, hi_ff, rise_ff;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // select and clock as seen on the wire
  assign sel = pin_oe_n[PIN_SS] | pin_o[PIN_SS];
  assign sck = ~pin_oe_n[PIN_SCK] & pin_o[PIN_SCK];
  // run lengths and edge counts
  always_ff @(posedge ref_clk)
  begin
    sel_q_ff <= sel;
    sck_q_ff <= sck;
    low_ff <= config_reset_n ? 16'h0000 : low_ff + 16'h0001;
    hi_ff <= sel ? hi_ff + 16'h0001 : 16'h0000;
    if (sel_q_ff & ~sel)
      rise_ff <= 16'h0000;
    else if (sck & ~sck_q_ff)
      rise_ff <= rise_ff + 16'h0001;
    if (sys_rst | internal_reset)
      fall_ff <= 2'h0;
    else if (sel_q_ff & ~sel & ~config_done & fall_ff != 2'h3)
      fall_ff <= fall_ff + 2'h1;
  end
  a_supply_hold: assert property (
    supply_good != 4'hf |-> ##[3:4] internal_reset)
    else $error("reset not held for low supply");
  a_pin_hold: assert property (
    low_ff >= 16'h0010 |-> internal_reset)
    else $error("reset not held for low pin");
  a_quiet_pins: assert property (
    (internal_reset || !master_mode) [*3] |-> pin_oe_n == 4'hf && !config_done)
    else $error("pins driven outside loading");
  a_user_pins: assert property (
    config_done [*2] |-> pin_o == $past(user_o) && pin_oe_n == $past(user_oe_n))
    else $error("pins not handed to user");
  a_sck_idle: assert property (
    !config_done && sel |-> !sck)
    else $error("clock runs while deselected");
  a_so_fall: assert property (
    !config_done && !$past(config_done) && !pin_oe_n[PIN_SO]
      && $changed(pin_o[PIN_SO]) |-> !pin_o[PIN_SCK])
    else $error("data out changed with clock high");
  a_wake_gap: assert property (
    sel_q_ff && !sel && fall_ff == 2'h1 && !config_done
      |-> hi_ff >= WAKE_GAP_CYC - 1)
    else $error("gap after wake too short");
  a_read_len: assert property (
    sel && !sel_q_ff && fall_ff == 2'h2 && !$past(config_done)
      |-> rise_ff == READ_BITS + IMAGE_BITS)
    else $error("wrong clock count in read");
  c_done: cover property ($rose(config_done));
  c_stall: cover property ((cfg_valid && !cfg_ready) [*8]);
  c_slave: cover property ((!internal_reset && !master_mode) [*8]);
endmodule : scl_asserts
bind scl_loader scl_asserts #(.IMAGE_BITS(IMAGE_BITS)) chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .supply_good(supply_good),
  .config_reset_n(config_reset_n), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
  .user_o(user_o), .user_oe_n(user_oe_n), .internal_reset(internal_reset),
  .master_mode(master_mode), .config_done(config_done),
  .cfg_valid(cfg_valid), .cfg_ready(cfg_ready)
);
`default_nettype wire

//--- testbench/scl_prom_model.sv
// Purpose: serial memory answering the loader
// Assumes: clock idles low, select active low
// Notes: byte at address a is base plus a times 8'h1d
`timescale 1ns/1ps
`default_nettype none
module scl_prom_model (
  input wire logic ss_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] base,
  output logic miso,
  output logic [7:0] rd_cmd,
  output logic [23:0] rd_addr,
  output int wake_cnt,
  output int pd_cnt
);
  logic [39:0] sh;
  logic [7:0] cur;
  logic drive;
  int nbit, bidx;
  // idle: output released to its pull-up
  initial
  begin
    miso = 1'b1;
    drive = 1'b0;
    wake_cnt = 0;
    pd_cnt = 0;
  end
  // new command on each select fall
  always @(negedge ss_n)
  begin
    nbit = 0;
    drive = 1'b0;
  end
  // decode at once on rising clock
  always @(posedge sck)
    if (!ss_n)
    begin
      sh = {sh[38:0], mosi};
      nbit++;
      if (nbit == 8 && sh[7:0] == 8'hab)
        wake_cnt++;
      if (nbit == 8 && sh[7:0] == 8'hb9)
        pd_cnt++;
      if (nbit == 40 && sh[39:32] == 8'h0b)
      begin
        rd_cmd = sh[39:32];
        rd_addr = sh[31:8];
        drive = 1'b1;
        bidx = 0;
      end
    end
  // data msb first on falling clock
  always @(negedge sck)
    if (!ss_n && drive)
    begin
      cur = base + 8'(rd_addr + 24'(bidx / 8)) * 8'h1d;
      miso = cur[7 - bidx % 8];
      bidx++;
    end
  // released when deselected
  always @(posedge ss_n)
    miso = 1'b1;
endmodule : scl_prom_model
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the serial image loader
// Assumes: memory model on the four port pins
// Notes: short image so the buffer fills and stalls the link
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import scl_pkg::*;
;
  localparam int IMG = 256;
  logic ref_clk, sys_rst, config_reset_n, test_reset_cmd, power_down_en;
  logic cfg_ready, strap_lvl, internal_reset, master_mode, config_done;
  logic cfg_valid, miso, rate_fast;
  logic [3:0] gpio_in;
  logic [3:0] supply_good, user_o, user_oe_n, pin_i, pin_o, pin_oe_n;
  logic [7:0] cfg_data, base, rd_cmd;
  logic [23:0] rd_addr;
  int wake_cnt, pd_cnt, err_count, comparisons;
  // 50 MHz core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // wire levels: select strapped, data in from the memory
  assign pin_i[0] = pin_oe_n[0] ? strap_lvl : pin_o[0];
  assign pin_i[1] = pin_oe_n[1] ? 1'b0 : pin_o[1];
  assign pin_i[2] = pin_oe_n[2] ? 1'b1 : pin_o[2];
  assign pin_i[3] = pin_oe_n[3] ? miso : pin_o[3];
  scl_loader #(.IMAGE_BITS(IMG), .FIFO_DEPTH(16)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .supply_good(supply_good),
    .config_reset_n(config_reset_n), .test_reset_cmd(test_reset_cmd),
    .rate_fast(rate_fast), .power_down_en(power_down_en), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .user_o(user_o),
    .user_oe_n(user_oe_n), .gpio_in(gpio_in),
    .internal_reset(internal_reset),
    .master_mode(master_mode), .config_done(config_done),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data)
  );
  scl_prom_model mem_u (
    .ss_n(pin_i[0]), .sck(pin_i[1]), .mosi(pin_i[2]), .base(base),
    .miso(miso), .rd_cmd(rd_cmd), .rd_addr(rd_addr),
    .wake_cnt(wake_cnt), .pd_cnt(pd_cnt)
  );
  // expected image byte
  function automatic logic [7:0] exp_byte(input int i);
    return base + 8'(i) * 8'h1d;
  endfunction : exp_byte
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // one load: fill until stall, drain at random, then hand pins over
  task automatic run_load(input logic pd, input int loads, input int pds,
                          input logic fast);
    int n, got, rises;
    logic prev;
    power_down_en <= pd;
    rate_fast <= fast;
    base <= 8'($urandom);
    // slow rate has four times the bit time of the fast rate; the wait is doubled
    repeat (fast ? 4000 : 8000) @(posedge ref_clk);
    rises = 0;
    prev = pin_o[1];
    repeat (200)
    begin
      @(posedge ref_clk);
      rises += int'(pin_o[1] && !prev);
      prev = pin_o[1];
    end
    check("stall", rises, 0);
    check("first", {cfg_valid, cfg_data}, {1'b1, exp_byte(0)});
    got = 0;
    for (n = 0; n < 20000 && got < IMG / 8; n++)
    begin
      @(negedge ref_clk);
      if (cfg_valid && cfg_ready)
      begin
        check("byte", cfg_data, exp_byte(got));
        got++;
      end
      @(posedge ref_clk);
      cfg_ready <= 1'($urandom);
    end
    for (n = 0; n < 3000 && !config_done; n++)
      @(posedge ref_clk);
    check("bytes", {cfg_valid, 8'(got)}, IMG / 8);
    check("done", {master_mode, config_done}, 2'h3);
    check("wake", wake_cnt, loads);
    check("cmd", {rd_cmd, rd_addr}, 32'h0b000000);
    check("pd", pd_cnt, pds);
    user_o <= 4'ha;
    user_oe_n <= 4'h5;
    repeat (4) @(posedge ref_clk);
    check("user", {pin_oe_n, pin_o}, 8'h5a);
    repeat (30)
    begin
      @(posedge ref_clk);
      user_o <= 4'($urandom);
      user_oe_n <= 4'($urandom);
    end
    user_o <= 4'hf;
    user_oe_n <= 4'hf;
  endtask : run_load
  // watchdog
  initial
  begin
    repeat (50000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end
  initial
  begin
    base = 8'($urandom(60898));
    err_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    supply_good = 4'hd;
    config_reset_n = 1'b1;
    test_reset_cmd = 1'b0;
    power_down_en = 1'b0;
    rate_fast = 1'b1;
    cfg_ready = 1'b0;
    strap_lvl = 1'b1;
    user_o = 4'hf;
    user_oe_n = 4'hf;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (600) @(posedge ref_clk);
    check("supply", internal_reset, 1);
    supply_good <= 4'hf;
    repeat (400) @(posedge ref_clk);
    check("wait", internal_reset, 1);
    repeat (150) @(posedge ref_clk);
    check("free", internal_reset, 0);
    run_load(1'b1, 1, 1, 1'b1);
    // glitch below the filter length is ignored
    config_reset_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    config_reset_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check("glitch", {internal_reset, config_done}, 2'b01);
    // pin held low stands for a slow memory not yet ready
    config_reset_n <= 1'b0;
    cfg_ready <= 1'b0;
    repeat (30) @(posedge ref_clk);
    check("pin", {internal_reset, config_done}, 2'b10);
    config_reset_n <= 1'b1;
    run_load(1'b0, 2, 1, 1'b0);
    test_reset_cmd <= 1'b1;
    strap_lvl <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check("test", internal_reset, 1);
    test_reset_cmd <= 1'b0;
    repeat (200) @(posedge ref_clk);
    check("slave", {master_mode, config_done, pin_oe_n}, 6'h0f);
    check("gpio", gpio_in, 4'hc);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
